// file: bench/lmi_host_model.sv
`timescale 1ns/10ps
module lmi_host_model
  import lmi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output lmi_bus_s        bus
);
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    d = rdata;
  endtask
endmodule // lmi_host_model

// file: bench/lmi_link_monitor_assertions.sv
`timescale 1ns/10ps
module lmi_link_monitor_chk
  import lmi_pkg::*;
#(
  parameter bit IS_TRANSMITTER = 1'b1,
  parameter bit HAS_SLAVE_PORT = 1'b1
)(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire lmi_bus_s   bus,
  input wire logic [7:0] rdata,
  input wire lmi_event_s ev,
  input wire logic       irq_pin_oe,
  input wire logic       afh_disable,
  input wire logic       reload_stored,
  input wire logic       force_reconfig,
  input wire logic [7:0] latency_sel,
  input wire logic [1:0] tx_power_sel,
  input wire logic [1:0] rx_power_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(logic [7:0] a);
    bus.wr && bus.addr == a;
  endsequence
  a_afh_follow: assert property (s_wr(OFS_LINK_POLICY) |=>
    afh_disable == $past(bus.wdata[2])) else $error("bad afh_disable");
  a_reconf_follow: assert property (s_wr(OFS_LINK_POLICY) |=>
    force_reconfig == $past(bus.wdata[4])) else $error("bad force_reconfig");
  a_latency_follow: assert property (s_wr(OFS_LATENCY) |=>
    latency_sel == $past(bus.wdata)) else $error("bad latency_sel");
  a_tx_power_follow: assert property (s_wr(OFS_TX_POWER) |=>
    tx_power_sel == $past(bus.wdata[1:0])) else $error("bad tx_power_sel");
  a_rx_power_follow: assert property (s_wr(OFS_RX_POWER) |=>
    rx_power_sel == (IS_TRANSMITTER ? $past(bus.wdata[1:0]) : $past(rx_power_sel)))
    else $error("bad rx_power_sel");
  a_reload_cause: assert property (reload_stored |-> $past(ev.link_init_fail))
    else $error("reload without failed init");
  a_state_reserved: assert property (bus.rd && bus.addr == OFS_LINK_STATE |=>
    rdata[7:1] == 7'h00) else $error("link state upper bits set");
  a_pin_present: assert property (irq_pin_oe == (IS_TRANSMITTER || HAS_SLAVE_PORT))
    else $error("bad irq_pin_oe");
endmodule // lmi_link_monitor_chk

bind lmi_link_monitor lmi_link_monitor_chk #(
  .IS_TRANSMITTER(IS_TRANSMITTER), .HAS_SLAVE_PORT(HAS_SLAVE_PORT)
) u_chk (
  .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .ev(ev), .irq_pin_oe(irq_pin_oe),
  .afh_disable(afh_disable), .reload_stored(reload_stored), .force_reconfig(force_reconfig),
  .latency_sel(latency_sel), .tx_power_sel(tx_power_sel), .rx_power_sel(rx_power_sel)
);

// file: bench/tb_link_monitor_interrupt_unit.sv
`timescale 1ns/10ps
`define CK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_link_monitor_interrupt_unit
  import lmi_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  lmi_rate_e   rate = RATE_HIGH;
  lmi_event_s  ev = '0;
  lmi_bus_s    bus;
  logic [7:0]  rdata, latency_sel, rv;
  logic [1:0]  tx_power_sel, rx_power_sel;
  logic        irq_pin, irq_pin_oe, mute, afh_disable, reload_stored, force_reconfig;
  logic [31:0] seed = 32'h0c77;
  logic [15:0] rst_q[$] = '{16'h0200, 16'h0300, 16'h04ff, 16'h0500, 16'h3600, 16'h3700,
                            16'h38ff, 16'h4903, 16'h5202, 16'h5300, 16'h5603, 16'h7a00};
  int          err_count = 0;
  int          check_count = 0;
  int          k, m;
  always #2 clk = ~clk;
  lmi_host_model host (.clk(clk), .rdata(rdata), .bus(bus));
  lmi_link_monitor uut (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .rate(rate), .ev(ev),
    .irq_pin(irq_pin), .irq_pin_oe(irq_pin_oe), .mute(mute), .afh_disable(afh_disable),
    .reload_stored(reload_stored), .force_reconfig(force_reconfig),
    .latency_sel(latency_sel), .tx_power_sel(tx_power_sel), .rx_power_sel(rx_power_sel)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Event strobes: one cycle high, then one low
  task automatic pulse(input logic [7:0] p, input int n);
    repeat (n)
    begin
      @(posedge clk);
      ev <= lmi_event_s'(ev | p);
      @(posedge clk);
      ev <= lmi_event_s'(ev & ~p);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    `CK("rdata", e, rv)
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    host.wr(OFS_IRQ_FLAGS, 8'h7f);
    foreach (rst_q[i]) rchk(rst_q[i][15:8], rst_q[i][7:0]);
    `CK("irq_pin", 1'b1, irq_pin)
    for (int v = 0; v < 4; v++)
    begin
      host.wr(OFS_TX_POWER, 8'(v));
      host.wr(OFS_RX_POWER, 8'(v));
      host.wr(OFS_LATENCY, 8'(2 * (v % 3)));
      `CK("tx_power_sel", 2'(v), tx_power_sel)
      `CK("rx_power_sel", 2'(v), rx_power_sel)
      `CK("latency_sel", 8'(2 * (v % 3)), latency_sel)
      seed = lfsr(seed);
      @(posedge clk);
      rate <= lmi_rate_e'(2'(seed[15:8] % 3));
      host.wr(OFS_LINK_POLICY, seed[7:0]);
      rchk(OFS_LINK_POLICY, seed[7:0] & POLICY_MASK);
      `CK("afh_disable", seed[2], afh_disable)
      `CK("force_reconfig", seed[4], force_reconfig)
    end
    // Wakeup enable: pin follows power state only
    host.wr(OFS_IRQ_CONFIG, 8'hff);
    rchk(OFS_IRQ_CONFIG, CONFIG_MASK);
    `CK("irq_pin", 1'b0, irq_pin)
    @(posedge clk);
    ev.powered_up <= 1'b1;
    rchk(OFS_IRQ_FLAGS, 8'h02);
    `CK("irq_pin", 1'b1, irq_pin)
    seed = lfsr(seed);
    k = 1 + seed[7:0] % 20;
    m = 2 + seed[15:8] % 9;
    host.wr(OFS_LINK_POLICY, 8'h08);
    host.wr(OFS_WARN_LEVEL, 8'(255 - k));
    host.wr(OFS_ALARM_LEVEL, 8'(m));
    host.wr(OFS_IRQ_CONFIG, 8'ha4);
    host.wr(OFS_IRQ_FLAGS, 8'h7f);
    rchk(OFS_IRQ_FLAGS, 8'h00);
    `CK("irq_pin", 1'b0, irq_pin)
    pulse(8'h40, k);
    pulse(8'h20, m);
    pulse(8'h80, 13);
    rchk(OFS_IRQ_FLAGS, 8'h00);
    pulse(8'h80, 1);
    rchk(OFS_LINK_QUALITY, 8'(255 - k));
    rchk(OFS_IRQ_FLAGS, 8'h20);
    `CK("irq_pin", 1'b1, irq_pin)
    pulse(8'h80, 18);
    rchk(OFS_LOST_PACKETS, 8'(m));
    rchk(OFS_IRQ_FLAGS, 8'h24);
    `CK("mute", 1'b0, mute)
    host.wr(OFS_ALARM_LEVEL, 8'(m - 1));
    repeat (2) @(negedge clk);
    `CK("mute", 1'b1, mute)
    host.wr(OFS_WARN_LEVEL, 8'h00);
    host.wr(OFS_ALARM_LEVEL, 8'hff);
    host.wr(OFS_IRQ_FLAGS, 8'h04);
    rchk(OFS_IRQ_FLAGS, 8'h20);
    host.wr(OFS_IRQ_FLAGS, 8'h7f);
    `CK("irq_pin", 1'b0, irq_pin)
    host.wr(OFS_IRQ_CONFIG, 8'h40);
    @(posedge clk);
    ev.link_up <= 1'b1;
    rchk(OFS_LINK_STATE, 8'h01);
    @(posedge clk);
    ev.link_up <= 1'b0;
    rchk(OFS_IRQ_FLAGS, 8'h40);
    `CK("irq_pin", 1'b0, irq_pin)
    // Pins-changed stays masked, remote-done drives the pin
    host.wr(OFS_IRQ_CONFIG, 8'h90);
    host.wr(OFS_IRQ_FLAGS, 8'h7f);
    pulse(8'h02, 1);
    rchk(OFS_IRQ_FLAGS, 8'h08);
    `CK("irq_pin", 1'b0, irq_pin)
    pulse(8'h04, 1);
    rchk(OFS_IRQ_FLAGS, 8'h18);
    `CK("irq_pin", 1'b1, irq_pin)
    host.wr(OFS_IRQ_FLAGS, 8'h10);
    rchk(OFS_IRQ_FLAGS, 8'h08);
    `CK("irq_pin", 1'b0, irq_pin)
    host.wr(OFS_LINK_POLICY, 8'h40);
    pulse(8'h01, 1);
    k = 0;
    repeat (3)
    begin
      @(negedge clk);
      k += int'(reload_stored === 1'b1);
    end
    `CK("reload_stored", 1, k)
    complete_run();
  end
endmodule // tb_link_monitor_interrupt_unit

// file: hw/lmi_link_monitor.sv
// Chosen here: the strobed register port.
`timescale 1ns/10ps
// Notes on behaviour
// - Quality reads 255 minus packets lost in last 14-frame window.
// - Packets per frame are 8, 4 or 2 by audio sample rate.
// - Permanent-loss count over latest 32-frame window, saturating at 255.
// - Quality at or below warning level sets poor-quality flag.
// - Permanent loss at or above alarm level sets link-error flag.
// - Transmitter side has both counters; receiver side only permanent loss.
// - Link-state bit 0 shows link established; upper bits read zero.
// - Policy bit 6 reloads stored setup on failed init; bit 4 forces reconfig.
// - Policy bit 3 mutes audio while permanent loss exceeds alarm level.
// - Policy bit 2 stops frequency hopping; reserved policy bits stay zero.
// - Latency select: 0 short, 2 nominal, 4 high.
// - Power select 0..3 maps to -20, -10, -5, 0 dBm.
// - Transmitter side host writes both its and receiver power settings.
// - Interrupt stays active until host writes one to flag; 0x7f clears all.
// - Config bit 7 picks interrupt polarity, one means active high.
// - Status flags: 6 broken, 5 poor, 4 remote done, 3 pins, 2 error, 1 wake.
// - Config bits 6..2 enable the flag at the same position.
// - Wakeup enable makes the pin track power state only.
// - Receiver pin exists only with a serial slave interface.
// - Interrupt state is local to this end.
// - Poor-quality and remote-done interrupts exist only on transmitter side.
module lmi_link_monitor
  import lmi_pkg::*;
#(
  parameter bit IS_TRANSMITTER = 1'b1,
  parameter bit HAS_SLAVE_PORT = 1'b1
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire lmi_bus_s   bus,
  output logic [7:0]      rdata,
  input  wire lmi_rate_e  rate,
  input  wire lmi_event_s ev,
  output logic            irq_pin,
  output logic            irq_pin_oe,
  output logic            mute,
  output logic            afh_disable,
  output logic            reload_stored,
  output logic            force_reconfig,
  output logic [7:0]      latency_sel,
  output logic [1:0]      tx_power_sel,
  output logic [1:0]      rx_power_sel
);

  lmi_state_s state_reg;
  lmi_state_s state_next;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (QUALITY_FRAMES < 1 || QUALITY_FRAMES > 32 || LOSS_FRAMES < 1 || LOSS_FRAMES > 64)
  begin : g_bad_window
    $error("window length does not fit its frame counter");
  end

  // ---------------------------------------------------------------
  // Per-frame packet budget
  // ---------------------------------------------------------------
  logic [3:0] ppf;
  always_comb
  begin
    case (rate)
      RATE_HIGH: ppf = PPF_HIGH;
      RATE_MID:  ppf = PPF_MID;
      RATE_LOW:  ppf = PPF_LOW;
      default:   ppf = PPF_HIGH;
    endcase
  end

  logic [7:0] flag_avail;
  assign flag_avail = IS_TRANSMITTER ? FLAG_MASK : (FLAG_MASK & ~TX_ONLY_FLAGS);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [7:0] set_ev;
  logic [7:0] clr_ev;
  logic       link_fell;
  logic       wake_rise;
  logic [7:0] enabled;
  logic       any_irq;
  logic       active;

  always_comb
  begin
    state_next = state_reg;
    state_next.link_up    = ev.link_up;
    state_next.powered_up = ev.powered_up;
    link_fell  = state_reg.link_up & ~ev.link_up;
    wake_rise  = ~state_reg.powered_up & ev.powered_up;

    // Window counters
    if (IS_TRANSMITTER && ev.pkt_lost && state_reg.q_acc != 9'h0ff)
      state_next.q_acc = state_reg.q_acc + 9'h001;
    if (ev.pkt_perm_lost && state_reg.p_acc != 9'h0ff)
      state_next.p_acc = state_reg.p_acc + 9'h001;
    if (ev.frame_tick)
    begin
      if (IS_TRANSMITTER)
      begin
        if (state_reg.q_frame == 5'(QUALITY_FRAMES - 1))
        begin
          state_next.q_frame = 5'h00;
          state_next.quality = COUNT_MAX - state_next.q_acc[7:0];
          state_next.q_acc   = 9'h000;
        end
        else
          state_next.q_frame = state_reg.q_frame + 5'h01;
      end
      if (state_reg.p_frame == 6'(LOSS_FRAMES - 1))
      begin
        state_next.p_frame   = 6'h00;
        state_next.perm_loss = state_next.p_acc[7:0];
        state_next.p_acc     = 9'h000;
      end
      else
        state_next.p_frame = state_reg.p_frame + 6'h01;
    end

    // Event flags
    set_ev = 8'h00;
    set_ev[BIT_LINK_BROKEN]  = link_fell;
    set_ev[BIT_POOR_QUALITY] = IS_TRANSMITTER && (state_reg.quality <= state_reg.warn_level);
    set_ev[BIT_REMOTE_DONE]  = ev.remote_done;
    set_ev[BIT_PINS_CHANGED] = ev.pins_changed;
    set_ev[BIT_LINK_ERROR]   = state_reg.perm_loss >= state_reg.alarm_level;
    set_ev[BIT_WAKEUP]       = wake_rise;
    set_ev = set_ev & flag_avail;

    // Register writes
    clr_ev = 8'h00;
    state_next.reload_req = 1'b0;
    if (bus.wr)
    begin
      case (bus.addr)
        OFS_IRQ_FLAGS:   clr_ev = bus.wdata & FLAG_MASK;
        OFS_LINK_POLICY: state_next.policy = bus.wdata & POLICY_MASK;
        OFS_WARN_LEVEL:  state_next.warn_level = bus.wdata;
        OFS_ALARM_LEVEL: state_next.alarm_level = bus.wdata;
        OFS_LATENCY:     state_next.latency = bus.wdata;
        OFS_IRQ_CONFIG:  state_next.config_bits = bus.wdata & CONFIG_MASK;
        OFS_TX_POWER:    state_next.tx_power = {6'h00, bus.wdata[1:0]};
        OFS_RX_POWER:
          if (IS_TRANSMITTER)
            state_next.rx_power = {6'h00, bus.wdata[1:0]};
        default: ;
      endcase
    end
    // Set wins over clear
    state_next.flags = ((state_reg.flags & ~clr_ev) | set_ev) & flag_avail;

    if (ev.link_init_fail && state_reg.policy[BIT_POL_RELOAD])
      state_next.reload_req = 1'b1;

    // Read data
    state_next.rdata = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        OFS_IRQ_FLAGS:    state_next.rdata = state_reg.flags;
        OFS_LINK_STATE:   state_next.rdata = {7'h00, state_reg.link_up};
        OFS_LINK_QUALITY: state_next.rdata = IS_TRANSMITTER ? state_reg.quality : 8'h00;
        OFS_LOST_PACKETS: state_next.rdata = state_reg.perm_loss;
        OFS_LINK_POLICY:  state_next.rdata = state_reg.policy;
        OFS_WARN_LEVEL:   state_next.rdata = state_reg.warn_level;
        OFS_ALARM_LEVEL:  state_next.rdata = state_reg.alarm_level;
        OFS_LATENCY:      state_next.rdata = state_reg.latency;
        OFS_IRQ_CONFIG:   state_next.rdata = state_reg.config_bits;
        OFS_TX_POWER:     state_next.rdata = state_reg.tx_power;
        OFS_RX_POWER:     state_next.rdata = state_reg.rx_power;
        default:          state_next.rdata = 8'h00;
      endcase
    end

    // Interrupt level
    enabled = state_next.flags & state_next.config_bits & flag_avail;
    any_irq = |enabled[BIT_LINK_BROKEN:BIT_LINK_ERROR];
    if (state_next.config_bits[BIT_WAKEUP])
      active = state_next.powered_up;
    else
      active = any_irq;
    state_next.irq = active;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg             <= '0;
      state_reg.quality     <= COUNT_MAX;
      state_reg.latency     <= RST_LATENCY;
      state_reg.tx_power    <= RST_POWER;
      state_reg.rx_power    <= RST_POWER;
      state_reg.warn_level  <= RST_ZERO;
      state_reg.alarm_level <= COUNT_MAX;
    end
    else
      state_reg <= state_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata          = state_reg.rdata;
  assign irq_pin        = state_reg.config_bits[BIT_POLARITY] ? state_reg.irq
                                                              : ~state_reg.irq;
  assign irq_pin_oe     = IS_TRANSMITTER | HAS_SLAVE_PORT;
  assign mute           = state_reg.policy[BIT_POL_MUTE] &&
                          (state_reg.perm_loss > state_reg.alarm_level);
  assign afh_disable    = state_reg.policy[BIT_POL_NO_AFH];
  assign reload_stored  = state_reg.reload_req;
  assign force_reconfig = state_reg.policy[BIT_POL_RECONF];
  assign latency_sel    = state_reg.latency;
  assign tx_power_sel   = state_reg.tx_power[1:0];
  assign rx_power_sel   = state_reg.rx_power[1:0];

endmodule // lmi_link_monitor

// file: hw/lmi_pkg.sv
package lmi_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_FLAGS      = 8'h02;
  localparam logic [7:0] OFS_LINK_STATE     = 8'h03;
  localparam logic [7:0] OFS_LINK_QUALITY   = 8'h04;
  localparam logic [7:0] OFS_LOST_PACKETS   = 8'h05;
  localparam logic [7:0] OFS_LINK_POLICY    = 8'h36;
  localparam logic [7:0] OFS_WARN_LEVEL     = 8'h37;
  localparam logic [7:0] OFS_ALARM_LEVEL    = 8'h38;
  localparam logic [7:0] OFS_RX_POWER       = 8'h49;
  localparam logic [7:0] OFS_LATENCY        = 8'h52;
  localparam logic [7:0] OFS_IRQ_CONFIG     = 8'h53;
  localparam logic [7:0] OFS_TX_POWER       = 8'h56;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_LINK_BROKEN  = 6;
  localparam int BIT_POOR_QUALITY = 5;
  localparam int BIT_REMOTE_DONE  = 4;
  localparam int BIT_PINS_CHANGED = 3;
  localparam int BIT_LINK_ERROR   = 2;
  localparam int BIT_WAKEUP       = 1;
  localparam int BIT_POLARITY     = 7;
  localparam int BIT_POL_RELOAD   = 6;
  localparam int BIT_POL_RECONF   = 4;
  localparam int BIT_POL_MUTE     = 3;
  localparam int BIT_POL_NO_AFH   = 2;

  // Writable masks and transmitter-only flags
  localparam logic [7:0] FLAG_MASK      = 8'h7e;
  localparam logic [7:0] CONFIG_MASK    = 8'hfe;
  localparam logic [7:0] POLICY_MASK    = 8'h5c;
  localparam logic [7:0] TX_ONLY_FLAGS  = 8'h30;

  // ---------------------------------------------------------------
  // Window sizes, packets per frame, latency codes and reset values
  // ---------------------------------------------------------------
  localparam int         QUALITY_FRAMES = 14;
  localparam int         LOSS_FRAMES    = 32;
  localparam logic [3:0] PPF_HIGH       = 4'h8;
  localparam logic [3:0] PPF_MID        = 4'h4;
  localparam logic [3:0] PPF_LOW        = 4'h2;
  localparam logic [7:0] COUNT_MAX      = 8'hff;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_LATENCY    = 8'h02;
  localparam logic [7:0] RST_POWER      = 8'h03;
  localparam logic [7:0] LAT_SHORT      = 8'h00;
  localparam logic [7:0] LAT_NOMINAL    = 8'h02;
  localparam logic [7:0] LAT_HIGH       = 8'h04;

  typedef enum logic [1:0] {
    RATE_HIGH,
    RATE_MID,
    RATE_LOW
  } lmi_rate_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lmi_bus_s;

  typedef struct packed {
    logic       frame_tick;
    logic       pkt_lost;
    logic       pkt_perm_lost;
    logic       link_up;
    logic       powered_up;
    logic       remote_done;
    logic       pins_changed;
    logic       link_init_fail;
  } lmi_event_s;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] config_bits;
    logic [7:0] policy;
    logic [7:0] warn_level;
    logic [7:0] alarm_level;
    logic [7:0] latency;
    logic [7:0] tx_power;
    logic [7:0] rx_power;
    logic [7:0] quality;
    logic [7:0] perm_loss;
    logic [8:0] q_acc;
    logic [8:0] p_acc;
    logic [4:0] q_frame;
    logic [5:0] p_frame;
    logic       link_up;
    logic       powered_up;
    logic       reload_req;
    logic [7:0] rdata;
    logic       irq;
  } lmi_state_s;

endpackage
